// file: rtl/split_timer_pkg.sv
`default_nettype none
package split_timer_pkg;
   // Register addresses on the special function register bus
   localparam logic [7:0] ADDR_CONTROL = 8'h91;
   localparam logic [7:0] ADDR_RELOAD_LOW = 8'h92;
   localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
   localparam logic [7:0] ADDR_COUNT_LOW = 8'h94;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'h95;
   // Control field positions
   localparam int BIT_HIGH_FLAG = 7;
   localparam int BIT_LOW_FLAG = 6;
   localparam int BIT_LOW_IRQ_EN = 5;
   localparam int BIT_CAPTURE_EN = 4;
   localparam int BIT_SPLIT = 3;
   localparam int BIT_RUN = 2;
   localparam int BIT_UNUSED = 1;
   localparam int BIT_EXT_SEL = 0;
   // Reset values and constants
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] BYTE_ONES = 8'hFF;
   localparam logic [7:0] CONTROL_WRITE_MASK = 8'hFD;
   // Dividers
   localparam int SYS_DIV = 12;
   localparam int EXT_DIV = 8;
   localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
   localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV - 1);
endpackage : split_timer_pkg
`default_nettype wire

// file: rtl/tick_select.sv
`timescale 1ns/10ps
`default_nettype none
// Picks one counting tick for one byte from the three sources
module tick_select
(
   // Selects
   input wire logic sys_sel_i,
   input wire logic ext_sel_i,
   // Sources, all on the system clock
   input wire logic div12_tick_i,
   input wire logic ext_tick_i,
   // Result
   output logic tick_o
);
   // System clock wins, else divided source
   always_comb
   begin
      if (sys_sel_i)
      begin
         tick_o = 1'b1;
      end
      else
      begin
         tick_o = ext_sel_i ? ext_tick_i : div12_tick_i;
      end
   end
endmodule : tick_select
`default_nettype wire

// file: rtl/split_autoreload_timer.sv
// Overview of operation
// R01 - Unsplit: 16-bit count, on FFFF wrap load reload pair, set high flag.
// R02 - Control bit 3 chooses one 16-bit or two 8-bit reload timers.
// R03 - Split: each byte reloads from its own reload byte on its overflow.
// R04 - Run bit 2 gates timer; in split mode only high byte, low runs.
// R05 - Clock select one gives system clock, else external bit picks /12 or /8.
// R06 - External divided-by-8 tick is synchronised to system clock before use.
// R07 - High flag bit 7 on high wrap; low flag bit 6 on any low wrap.
// R08 - With interrupt enable set, high flag setting raises interrupt request.
// R09 - Low-byte enable bit 5 also makes low overflow raise the interrupt.
// R10 - Flags never clear by hardware; software writes zero to clear.
// R11 - Handler checks both flags to find the interrupt source.
// R12 - Capture bit 4: on oscillator rising edge copy count into reload pair.
// R13 - Control bit 1 reads zero and ignores writes.
// R14 - Count registers hold halves of 16-bit count or the two 8-bit values.
// R15 - Counters add one per tick; register writes take effect at once.
`timescale 1ns/10ps
`default_nettype none
module split_autoreload_timer
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Special function register bus
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic sfr_wr_i,
   output logic [7:0] sfr_rdata_o,
   // Clock control bits held outside
   input wire logic high_byte_clock_select_i,
   input wire logic low_byte_clock_select_i,
   // Asynchronous sources
   input wire logic ext_osc_i,
   input wire logic lfo_i,
   // Interrupts
   input wire logic extended_interrupt_enable_i,
   output logic irq_o
);
   logic [7:0] control_r, control_nxt;
   logic [7:0] reload_low_r, reload_low_nxt;
   logic [7:0] reload_high_r, reload_high_nxt;
   logic [7:0] count_low_r, count_low_nxt;
   logic [7:0] count_high_r, count_high_nxt;
   logic [3:0] div12_r, div12_nxt;
   logic [2:0] ext_div_r, ext_div_nxt;
   logic ext_meta_r, ext_sync_r, ext_prev_r;
   logic lfo_meta_r, lfo_sync_r, lfo_prev_r;
   logic irq_r, irq_nxt;
   logic div12_tick, ext_tick, lfo_rise;
   logic low_tick, high_tick;
   logic split_mode, run_control, low_run, high_run;
   logic low_wrap, high_wrap;
   logic wr_ctrl, wr_rll, wr_rlh, wr_cl, wr_ch;

   assign split_mode = control_r[split_timer_pkg::BIT_SPLIT];
   assign run_control = control_r[split_timer_pkg::BIT_RUN];

   // Two-stage synchronisers; first stage is read only by the second
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         ext_meta_r <= 1'b0;
         ext_sync_r <= 1'b0;
         ext_prev_r <= 1'b0;
         lfo_meta_r <= 1'b0;
         lfo_sync_r <= 1'b0;
         lfo_prev_r <= 1'b0;
      end
      else
      begin
         ext_meta_r <= ext_osc_i;
         ext_sync_r <= ext_meta_r;
         ext_prev_r <= ext_sync_r;
         lfo_meta_r <= lfo_i;
         lfo_sync_r <= lfo_meta_r;
         lfo_prev_r <= lfo_sync_r;
      end
   end

   // R12 oscillator edge detect
   assign lfo_rise = lfo_sync_r & ~lfo_prev_r;

   // Dividers: /12 of system clock, /8 of synchronised oscillator edges
   always_comb
   begin
      div12_tick = (div12_r == split_timer_pkg::SYS_DIV_LAST);
      div12_nxt = div12_tick ? 4'h0 : div12_r + 4'h1;
      // R06 divider counts synchronised edges only
      ext_tick = 1'b0;
      ext_div_nxt = ext_div_r;
      if (ext_sync_r & ~ext_prev_r)
      begin
         ext_tick = (ext_div_r == split_timer_pkg::EXT_DIV_LAST);
         ext_div_nxt = ext_div_r + 3'h1;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         div12_r <= 4'h0;
         ext_div_r <= 3'h0;
      end
      else
      begin
         div12_r <= div12_nxt;
         ext_div_r <= ext_div_nxt;
      end
   end

   // R05 per-byte source selection
   tick_select u_low_sel
   (
      .sys_sel_i(low_byte_clock_select_i),
      .ext_sel_i(control_r[split_timer_pkg::BIT_EXT_SEL]),
      .div12_tick_i(div12_tick),
      .ext_tick_i(ext_tick),
      .tick_o(low_tick)
   );

   // In 16-bit mode the whole counter follows the low byte source
   tick_select u_high_sel
   (
      .sys_sel_i(split_mode ? high_byte_clock_select_i : low_byte_clock_select_i),
      .ext_sel_i(control_r[split_timer_pkg::BIT_EXT_SEL]),
      .div12_tick_i(div12_tick),
      .ext_tick_i(ext_tick),
      .tick_o(high_tick)
   );

   // Address decode
   assign wr_ctrl = sfr_wr_i && (sfr_addr_i == split_timer_pkg::ADDR_CONTROL);
   assign wr_rll = sfr_wr_i && (sfr_addr_i == split_timer_pkg::ADDR_RELOAD_LOW);
   assign wr_rlh = sfr_wr_i && (sfr_addr_i == split_timer_pkg::ADDR_RELOAD_HIGH);
   assign wr_cl = sfr_wr_i && (sfr_addr_i == split_timer_pkg::ADDR_COUNT_LOW);
   assign wr_ch = sfr_wr_i && (sfr_addr_i == split_timer_pkg::ADDR_COUNT_HIGH);

   // Counting, reload, capture, flags and interrupt
   always_comb
   begin
      control_nxt = control_r;
      reload_low_nxt = reload_low_r;
      reload_high_nxt = reload_high_r;
      count_low_nxt = count_low_r;
      count_high_nxt = count_high_r;
      // R04 run gating differs by mode
      low_run = split_mode ? 1'b1 : run_control;
      high_run = run_control;
      // R02 mode selects wrap conditions
      low_wrap = low_run && low_tick && (count_low_r == split_timer_pkg::BYTE_ONES);
      if (split_mode)
      begin
         high_wrap = high_run && high_tick && (count_high_r == split_timer_pkg::BYTE_ONES);
      end
      else
      begin
         high_wrap = low_wrap && (count_high_r == split_timer_pkg::BYTE_ONES);
      end
      // R15 increment by one per tick
      if (low_run && low_tick)
      begin
         count_low_nxt = count_low_r + 8'h01;
      end
      if (split_mode ? (high_run && high_tick) : low_wrap)
      begin
         count_high_nxt = count_high_r + 8'h01;
      end
      // R03 split reloads per byte
      if (split_mode)
      begin
         if (low_wrap)
         begin
            count_low_nxt = reload_low_r;
         end
         if (high_wrap)
         begin
            count_high_nxt = reload_high_r;
         end
      end
      // R01 full 16-bit reload
      else if (high_wrap)
      begin
         count_low_nxt = reload_low_r;
         count_high_nxt = reload_high_r;
      end
      // R15 software writes win over counting
      if (wr_cl)
      begin
         count_low_nxt = sfr_wdata_i;
      end
      if (wr_ch)
      begin
         count_high_nxt = sfr_wdata_i;
      end
      if (wr_rll)
      begin
         reload_low_nxt = sfr_wdata_i;
      end
      if (wr_rlh)
      begin
         reload_high_nxt = sfr_wdata_i;
      end
      // R12 capture overrides a reload write in the same cycle
      if (control_r[split_timer_pkg::BIT_CAPTURE_EN] && lfo_rise)
      begin
         reload_low_nxt = count_low_r;
         reload_high_nxt = count_high_r;
      end
      // R13 unused bit stays zero
      if (wr_ctrl)
      begin
         control_nxt = sfr_wdata_i & split_timer_pkg::CONTROL_WRITE_MASK;
      end
      // R10 hardware only sets flags, and a set beats a clearing write
      // R07 flag setting
      if (high_wrap)
      begin
         control_nxt[split_timer_pkg::BIT_HIGH_FLAG] = 1'b1;
      end
      if (low_wrap)
      begin
         control_nxt[split_timer_pkg::BIT_LOW_FLAG] = 1'b1;
      end
      // R08 R09 request is a level from enabled pending flags
      irq_nxt = extended_interrupt_enable_i &&
         (control_nxt[split_timer_pkg::BIT_HIGH_FLAG] ||
         (control_nxt[split_timer_pkg::BIT_LOW_FLAG] &&
         control_nxt[split_timer_pkg::BIT_LOW_IRQ_EN]));
      // R12 capture also requests
      if (extended_interrupt_enable_i && control_r[split_timer_pkg::BIT_CAPTURE_EN] && lfo_rise)
      begin
         irq_nxt = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         control_r <= split_timer_pkg::RESET_BYTE;
         reload_low_r <= split_timer_pkg::RESET_BYTE;
         reload_high_r <= split_timer_pkg::RESET_BYTE;
         count_low_r <= split_timer_pkg::RESET_BYTE;
         count_high_r <= split_timer_pkg::RESET_BYTE;
         irq_r <= 1'b0;
      end
      else
      begin
         control_r <= control_nxt;
         reload_low_r <= reload_low_nxt;
         reload_high_r <= reload_high_nxt;
         count_low_r <= count_low_nxt;
         count_high_r <= count_high_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign irq_o = irq_r;

   // R14 read mux; unmapped addresses read zero
   always_comb
   begin
      unique case (sfr_addr_i)
         split_timer_pkg::ADDR_CONTROL: sfr_rdata_o = control_r;
         split_timer_pkg::ADDR_RELOAD_LOW: sfr_rdata_o = reload_low_r;
         split_timer_pkg::ADDR_RELOAD_HIGH: sfr_rdata_o = reload_high_r;
         split_timer_pkg::ADDR_COUNT_LOW: sfr_rdata_o = count_low_r;
         split_timer_pkg::ADDR_COUNT_HIGH: sfr_rdata_o = count_high_r;
         default: sfr_rdata_o = 8'h00;
      endcase
   end

   // Assertions
   // R01 16-bit wrap reloads and flags
   a_full_reload: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R01
      (!split_mode && high_wrap && !wr_cl && !wr_ch) |=>
      (count_low_r == $past(reload_low_r) && count_high_r == $past(reload_high_r)
      && control_r[split_timer_pkg::BIT_HIGH_FLAG]))
      else $error("16-bit reload wrong");
   // R03 split low reload
   a_split_low: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R03
      (split_mode && low_wrap && !wr_cl) |=> count_low_r == $past(reload_low_r))
      else $error("split low reload wrong");
   // R04 stopped high byte holds
   a_high_stop: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R04
      (!run_control && !wr_ch) |=> $stable(count_high_r))
      else $error("high byte moved while stopped");
   // R04 low byte free-runs in split mode on system clock
   a_low_free: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R04
      (split_mode && low_byte_clock_select_i && !wr_cl
      && count_low_r != split_timer_pkg::BYTE_ONES)
      |=> count_low_r == $past(count_low_r) + 8'h01)
      else $error("low byte not running");
   // R07 low flag set on low wrap
   a_low_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R07
      low_wrap |=> control_r[split_timer_pkg::BIT_LOW_FLAG])
      else $error("low flag missed");
   // R10 high flag never clears without a write
   a_flag_sticky: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R10
      (control_r[split_timer_pkg::BIT_HIGH_FLAG] && !wr_ctrl)
      |=> control_r[split_timer_pkg::BIT_HIGH_FLAG])
      else $error("high flag cleared by hardware");
   // R08 interrupt follows high flag
   a_irq_high: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R08
      (control_r[split_timer_pkg::BIT_HIGH_FLAG] && $past(extended_interrupt_enable_i))
      |-> irq_o)
      else $error("interrupt missing");
   // R09 no low interrupt without enable
   a_irq_low_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R09
      (!control_r[split_timer_pkg::BIT_HIGH_FLAG]
      && !control_r[split_timer_pkg::BIT_LOW_IRQ_EN] && !$past(lfo_rise)) |-> !irq_o)
      else $error("spurious interrupt");
   // R13 unused bit reads zero
   a_unused_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R13
      !control_r[split_timer_pkg::BIT_UNUSED])
      else $error("unused bit set");
   // R12 capture copies count
   a_capture: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R12
      (control_r[split_timer_pkg::BIT_CAPTURE_EN] && lfo_rise)
      |=> (reload_low_r == $past(count_low_r) && reload_high_r == $past(count_high_r)))
      else $error("capture failed");
endmodule : split_autoreload_timer
`default_nettype wire

// file: dv/sfr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Core side of the register bus; every change lands on a falling edge
module sfr_host_model
(
   // Clock
   input wire logic ref_clk_i,
   // Register bus
   output logic [7:0] sfr_addr_o,
   output logic [7:0] sfr_wdata_o,
   output logic sfr_wr_o,
   input wire logic [7:0] sfr_rdata_i
);
   // Bus idle from time zero
   initial
   begin
      sfr_addr_o = 8'h00;
      sfr_wdata_o = 8'h00;
      sfr_wr_o = 1'b0;
   end
   // One-cycle strobe; data inverted afterwards so nothing leans on it
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk_i);
      sfr_addr_o = a;
      sfr_wdata_o = d;
      sfr_wr_o = 1'b1;
      @(negedge ref_clk_i);
      sfr_wr_o = 1'b0;
      sfr_wdata_o = ~d;
   endtask : write_reg
   // Read data is combinational, sampled late in the cycle
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk_i);
      sfr_addr_o = a;
      #4;
      d = sfr_rdata_i;
   endtask : read_reg
   // handler clears flags
   // Both flags read to find the source, then zero written to both flag bits
   task automatic service_flags(output logic [1:0] f);
      logic [7:0] c;
      read_reg(split_timer_pkg::ADDR_CONTROL, c);
      f = c[7:6];
      write_reg(split_timer_pkg::ADDR_CONTROL, c & 8'h3F);
   endtask : service_flags
endmodule : sfr_host_model
`default_nettype wire

// file: dv/split_autoreload_timer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module split_autoreload_timer_tb;
   localparam logic [7:0] CTL = split_timer_pkg::ADDR_CONTROL;
   localparam logic [7:0] RLL = split_timer_pkg::ADDR_RELOAD_LOW;
   localparam logic [7:0] RLH = split_timer_pkg::ADDR_RELOAD_HIGH;
   localparam logic [7:0] CL = split_timer_pkg::ADDR_COUNT_LOW;
   localparam logic [7:0] CH = split_timer_pkg::ADDR_COUNT_HIGH;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] sfr_addr;
   logic [7:0] sfr_wdata;
   logic sfr_wr;
   logic [7:0] sfr_rdata;
   logic hi_sel = 1'b1;
   logic lo_sel = 1'b1;
   logic ext_osc = 1'b0;
   logic lfo = 1'b0;
   logic irq_en = 1'b0;
   logic irq;
   int failures = 0;
   int comparisons = 0;
   logic [7:0] v;
   logic [7:0] w;
   logic [1:0] f;
   // Design and core model
   split_autoreload_timer i_split_autoreload_timer (.ref_clk_i(ref_clk), .rst_i(rst),
      .sfr_addr_i(sfr_addr), .sfr_wdata_i(sfr_wdata), .sfr_wr_i(sfr_wr),
      .sfr_rdata_o(sfr_rdata), .high_byte_clock_select_i(hi_sel),
      .low_byte_clock_select_i(lo_sel), .ext_osc_i(ext_osc), .lfo_i(lfo),
      .extended_interrupt_enable_i(irq_en), .irq_o(irq));
   sfr_host_model i_sfr_host_model (.ref_clk_i(ref_clk), .sfr_addr_o(sfr_addr),
      .sfr_wdata_o(sfr_wdata), .sfr_wr_o(sfr_wr), .sfr_rdata_i(sfr_rdata));
   // System clock, 100 MHz
   always #5 ref_clk = ~ref_clk;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_sfr_host_model.write_reg(a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      i_sfr_host_model.read_reg(a, d);
   endtask : rd
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED %0t byte %h not %h", $time, got, exp);
      end
   endtask : check_byte
   task automatic check_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED %0t bit %b not %b", $time, got, exp);
      end
   endtask : check_bit
   // Polls control until a flag rises; bounded so a dead counter fails
   task automatic wait_flag(input int b);
      for (int i = 0; i < 400; i++)
      begin
         rd(CTL, v);
         if (v[b] === 1'b1)
            return;
      end
      check_bit(1'b0, 1'b1);
   endtask : wait_flag
   task automatic complete_run();
      if (failures == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run
   // Reset values, the unmapped place and the dead control bit
   task automatic t_reset();
      for (int a = 0; a < 6; a++)
      begin
         rd(CTL + 8'(a), v);
         check_byte(v, 8'h00);
      end
      wr(CTL, 8'h02);
      rd(CTL, v);
      check_byte(v, 8'h00);
   endtask : t_reset
   // Full-width wrap, reload and stop
   task automatic t_wide();
      wr(RLL, 8'h34);
      wr(RLH, 8'h12);
      wr(CL, 8'hFD);
      wr(CH, 8'hFF);
      wr(CTL, 8'h04);
      wait_flag(7);
      check_byte(v & 8'hC0, 8'hC0);
      rd(CH, v);
      check_byte(v, 8'h12);
      rd(CL, v);
      check_bit(v >= 8'h34 && v < 8'h3C, 1'b1);
      wr(CTL, 8'hC0);
      rd(CL, v);
      repeat (20) @(negedge ref_clk);
      rd(CL, w);
      check_byte(w, v);
      rd(CTL, v);
      check_byte(v, 8'hC0);
      check_bit(irq, 1'b0);
   endtask : t_wide
   // Interrupt sources, low byte enable, split low reload
   task automatic t_irq();
      @(negedge ref_clk);
      irq_en = 1'b1;
      repeat (2) @(negedge ref_clk);
      check_bit(irq, 1'b1);
      i_sfr_host_model.service_flags(f);
      check_byte({6'h00, f}, 8'h03);
      repeat (2) @(negedge ref_clk);
      check_bit(irq, 1'b0);
      wr(CL, 8'hFE);
      wr(CTL, 8'h08);
      wait_flag(6);
      check_bit(v[7], 1'b0);
      check_bit(irq, 1'b0);
      rd(CL, v);
      check_bit(v >= 8'h34 && v < 8'h3C, 1'b1);
      rd(CH, v);
      check_byte(v, 8'h12);
      wr(CTL, 8'h68);
      repeat (2) @(negedge ref_clk);
      check_bit(irq, 1'b1);
      wr(CTL, 8'h28);
      repeat (2) @(negedge ref_clk);
      check_bit(irq, 1'b0);
   endtask : t_irq
   // Split high byte on the divided system clock
   task automatic t_split_high();
      hi_sel = 1'b0;
      wr(RLH, 8'h50);
      wr(CH, 8'hFE);
      wr(CTL, 8'h0C);
      wait_flag(7);
      // Enable still held from the interrupt scenario, so the high wrap requests
      check_bit(irq, 1'b1);
      rd(CH, v);
      check_bit(v >= 8'h50 && v < 8'h53, 1'b1);
      wr(CTL, 8'h00);
      hi_sel = 1'b1;
      irq_en = 1'b0;
   endtask : t_split_high
   // Divide by 12, then the external source: 16 edges give two ticks
   task automatic t_sources();
      lo_sel = 1'b0;
      wr(CL, 8'h00);
      wr(CH, 8'h00);
      wr(CTL, 8'h04);
      rd(CL, v);
      repeat (119) @(negedge ref_clk);
      rd(CL, w);
      check_byte(w - v, 8'h0A);
      wr(CTL, 8'h05);
      rd(CL, v);
      // Two cycles per level so the synchroniser sees every edge
      repeat (16)
      begin
         repeat (2) @(negedge ref_clk);
         ext_osc = 1'b1;
         repeat (2) @(negedge ref_clk);
         ext_osc = 1'b0;
      end
      repeat (6) @(negedge ref_clk);
      rd(CL, w);
      check_byte(w - v, 8'h02);
   endtask : t_sources
   // Capture of a stopped count on an oscillator rising edge
   task automatic t_capture();
      logic seen;
      seen = 1'b0;
      wr(CTL, 8'h00);
      lo_sel = 1'b1;
      wr(CL, 8'h78);
      wr(CH, 8'h56);
      wr(CTL, 8'h10);
      irq_en = 1'b1;
      @(negedge ref_clk);
      lfo = 1'b1;
      repeat (8)
      begin
         @(negedge ref_clk);
         seen = seen | (irq === 1'b1);
      end
      check_bit(seen, 1'b1);
      lfo = 1'b0;
      irq_en = 1'b0;
      rd(RLL, v);
      check_byte(v, 8'h78);
      rd(RLH, v);
      check_byte(v, 8'h56);
   endtask : t_capture
   // Main sequence after four reset cycles
   initial
   begin
      repeat (4) @(negedge ref_clk);
      rst = 1'b0;
      t_reset();
      t_wide();
      t_irq();
      t_split_high();
      t_sources();
      t_capture();
      complete_run();
   end
   // Watchdog, well beyond the few hundred cycles the run needs
   initial
   begin
      #200000;
      failures++;
      complete_run();
   end
endmodule : split_autoreload_timer_tb
`default_nettype wire
